// ---- logic/wdog_pkg.sv ----
// Constants shared by the counter array watchdog design
package wdog_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h04;
	localparam logic [7:0] CNT_LO_OFS = 8'h08;
	localparam logic [7:0] CNT_HI_OFS = 8'h0c;
	localparam logic [7:0] CH5_MODE_OFS = 8'h10;
	localparam logic [7:0] WD_OFFSET_OFS = 8'h14;
	localparam logic [7:0] WD_CMP_OFS = 8'h18;
	// Control register field positions
	localparam int CTRL_OVF_BIT = 7;
	localparam int CTRL_RUN_BIT = 6;
	localparam int CTRL_CH5_BIT = 5;
	// Mode register field positions
	localparam int MODE_IDLE_BIT = 7;
	localparam int MODE_ON_BIT = 6;
	localparam int MODE_LOCK_BIT = 5;
	localparam int MODE_SEL_LSB = 1;
	// Channel mode fields and the forced software timer mode
	localparam int CH5_ECOM_BIT = 6;
	localparam int CH5_MAT_BIT = 3;
	localparam logic [7:0] SW_TIMER_MODE = 8'h48;
	// Counter clock selections
	localparam logic [2:0] SEL_DIV12 = 3'h0;
	localparam logic [2:0] SEL_DIV4 = 3'h1;
	localparam logic [2:0] SEL_TIMER = 3'h2;
	localparam logic [2:0] SEL_SYSCLK = 3'h3;
	localparam logic [2:0] SEL_EXT_PIN = 3'h4;
	// Divider ratios of the system clock
	localparam int DIV_SLOW = 12;
	localparam int DIV_FAST = 4;
	// Values after reset
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [2:0] SEL_RESET = SEL_DIV12;
	localparam logic ON_RESET = 1'b1;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/tick_divider.sv ----
// Divides the system clock into a one-cycle enable pulse
`timescale 1ns/100ps
module tick_divider #(
	parameter int DIV = 12
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Enable pulse, once every DIV cycles
	output logic tick_out
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] count_r; // Cycles since last pulse

	// Free running modulo counter
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			count_r <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= (count_r == LAST);
			count_r <= (count_r == LAST) ? '0 : count_r + W'(1);
		end
	end
endmodule

// ---- logic/counter_array_watchdog.sv ----
// Counter array with channel five acting as a watchdog, AXI4-Lite slave
`timescale 1ns/100ps
module counter_array_watchdog
	import wdog_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Processor and clock sources
	input wire logic idle_mode_in,
	input wire logic timer_overflow_in,
	input wire logic ext_clock_pin_in,
	// Write address channel
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [ADDR_W-1:0] axi_awaddr_in,
	// Write data channel
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	// Write response channel
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	output logic [1:0] axi_bresp_out,
	// Read address channel
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	input wire logic [ADDR_W-1:0] axi_araddr_in,
	// Read data channel
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	// System reset request
	output logic wdt_reset_out
);
	// Bus state
	logic aw_have_r; // Write address latched
	logic w_have_r; // Write data latched
	logic [7:0] aw_addr_r; // Latched write address
	logic [7:0] w_byte_r; // Latched write data byte
	logic w_strb_r; // Low byte lane enabled
	// Block state
	logic [15:0] cnt_r; // Shared array counter
	logic ovf_flag_r; // 16-bit overflow flag
	logic run_bit_r; // Software run setting
	logic ch5_flag_r; // Channel five event flag
	logic on_bit_r; // Watchdog enable bit
	logic lock_bit_r; // Watchdog lock bit
	logic idle_bit_r; // Idle suspend setting
	logic [2:0] clk_sel_r; // Counter clock selection
	logic [7:0] ch5_mode_r; // Channel five mode as written
	logic [7:0] offset_r; // Watchdog offset byte
	logic [7:0] cmp_r; // Watchdog compare high byte
	// Pin synchroniser and edge detect
	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_s3_r;
	// Combinational terms
	logic div12_tick;
	logic div4_tick;
	logic sel_tick;
	logic wdt_en;
	logic cnt_adv;
	logic low_ovf;
	logic wr_do;
	logic wr_ok;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic force_rst;
	logic timeout_rst;
	logic [7:0] ch5_mode_eff;
	logic ch5_match;
	logic [7:0] rd_byte;
	logic rd_hit;

	// Prescalers for the two divided system clock rates
	tick_divider #(.DIV(DIV_SLOW)) u_div12 (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_out(div12_tick)
	);
	tick_divider #(.DIV(DIV_FAST)) u_div4 (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_out(div4_tick)
	);

	// External clock pin: two flops, then edge detect on the second
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= ext_clock_pin_in;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// Either bit enables; lock makes clearing the enable bit useless
	assign wdt_en = on_bit_r | lock_bit_r;

	// Counter clock source selection
	always_comb begin
		case (clk_sel_r)
			SEL_DIV12: sel_tick = div12_tick;
			SEL_DIV4: sel_tick = div4_tick;
			SEL_TIMER: sel_tick = timer_overflow_in;
			SEL_SYSCLK: sel_tick = 1'b1;
			SEL_EXT_PIN: sel_tick = pin_s2_r & ~pin_s3_r;
			default: sel_tick = div12_tick;
		endcase
	end

	// Counting: forced on by the watchdog, paused in idle if asked
	assign cnt_adv = sel_tick & (run_bit_r | wdt_en)
		& ~(idle_bit_r & idle_mode_in);
	assign low_ovf = cnt_adv & (cnt_r[7:0] == 8'hff);

	// Channel five mode is overridden while the watchdog runs
	assign ch5_mode_eff = wdt_en ? SW_TIMER_MODE : ch5_mode_r;
	assign ch5_match = cnt_adv & ch5_mode_eff[CH5_ECOM_BIT]
		& ch5_mode_eff[CH5_MAT_BIT] & (cnt_r == {cmp_r, offset_r});

	// Write decode: one write performed when address and data are in
	assign wr_do = aw_have_r & w_have_r & ~axi_bvalid_out;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_byte_r;
	assign wr_ok = wr_do & w_strb_r;

	// Reset sources
	assign force_rst = wr_ok & (wr_addr == CTRL_OFS) & wdt_en
		& wr_data[CTRL_CH5_BIT];
	assign timeout_rst = wdt_en & low_ovf
		& (cnt_r[15:8] == cmp_r);

	// Reset request pulse, never two cycles long
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wdt_reset_out <= 1'b0;
		end else begin
			wdt_reset_out <= ~wdt_reset_out
				& (timeout_rst | force_rst);
		end
	end

	// Shared counter; software writes are blocked under the watchdog
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt_r <= CNT_RESET;
		end else if (cnt_adv) begin
			cnt_r <= cnt_r + 16'h0001;
		end else if (wr_ok && !wdt_en) begin
			if (wr_addr == CNT_LO_OFS) begin
				cnt_r[7:0] <= wr_data;
			end else if (wr_addr == CNT_HI_OFS) begin
				cnt_r[15:8] <= wr_data;
			end
		end
	end

	// Control register; hardware set wins over software clear
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ovf_flag_r <= 1'b0;
			run_bit_r <= 1'b0;
			ch5_flag_r <= 1'b0;
		end else if (wr_ok && wr_addr == CTRL_OFS) begin
			ovf_flag_r <= wr_data[CTRL_OVF_BIT] | (cnt_adv & &cnt_r);
			run_bit_r <= wr_data[CTRL_RUN_BIT];
			ch5_flag_r <= wr_data[CTRL_CH5_BIT] | ch5_match;
		end else begin
			ovf_flag_r <= ovf_flag_r | (cnt_adv & &cnt_r);
			ch5_flag_r <= ch5_flag_r | ch5_match;
		end
	end

	// Mode register; source and idle frozen while enabled
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			on_bit_r <= ON_RESET;
			lock_bit_r <= 1'b0;
			idle_bit_r <= 1'b0;
			clk_sel_r <= SEL_RESET;
		end else if (wr_ok && wr_addr == MODE_OFS) begin
			on_bit_r <= wr_data[MODE_ON_BIT];
			// Lock only clears through reset
			lock_bit_r <= lock_bit_r | wr_data[MODE_LOCK_BIT];
			if (!wdt_en) begin
				idle_bit_r <= wr_data[MODE_IDLE_BIT];
				clk_sel_r <= wr_data[MODE_SEL_LSB +: 3];
			end
		end
	end

	// Channel five mode, offset and compare bytes
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ch5_mode_r <= BYTE_RESET;
			offset_r <= BYTE_RESET;
			cmp_r <= BYTE_RESET;
		end else if (wr_ok) begin
			if (wr_addr == CH5_MODE_OFS && !wdt_en) begin
				ch5_mode_r <= wr_data;
			end
			if (wr_addr == WD_OFFSET_OFS) begin
				offset_r <= wr_data;
			end
			// Refresh: written value is ignored under the watchdog
			if (wr_addr == WD_CMP_OFS) begin
				cmp_r <= wdt_en ? 8'(cnt_r[15:8] + offset_r)
					: wr_data;
			end
		end
	end

	// Write channels: accept address and data in either order
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_byte_r <= 8'h00;
			w_strb_r <= 1'b0;
			axi_awready_out <= 1'b0;
			axi_wready_out <= 1'b0;
			axi_bvalid_out <= 1'b0;
			axi_bresp_out <= RESP_OKAY;
		end else begin
			if (axi_awvalid_in && axi_awready_out) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= 8'(axi_awaddr_in);
			end else if (wr_do) begin
				aw_have_r <= 1'b0;
			end
			if (axi_wvalid_in && axi_wready_out) begin
				w_have_r <= 1'b1;
				w_byte_r <= axi_wdata_in[7:0];
				w_strb_r <= axi_wstrb_in[0];
			end else if (wr_do) begin
				w_have_r <= 1'b0;
			end
			// Ready only while the holding slot is free
			axi_awready_out <= ~(axi_awvalid_in & axi_awready_out)
				& ~(aw_have_r & ~wr_do);
			axi_wready_out <= ~(axi_wvalid_in & axi_wready_out)
				& ~(w_have_r & ~wr_do);
			if (wr_do) begin
				axi_bvalid_out <= 1'b1;
				axi_bresp_out <= (wr_addr[1:0] == 2'b00
					&& wr_addr <= WD_CMP_OFS) ? RESP_OKAY : RESP_SLVERR;
			end else if (axi_bready_in) begin
				axi_bvalid_out <= 1'b0;
			end
		end
	end

	// Read mux; run bit shows only what software set
	always_comb begin
		rd_hit = 1'b1;
		case (8'(axi_araddr_in))
			CTRL_OFS: rd_byte = {ovf_flag_r, run_bit_r, ch5_flag_r,
				5'h00};
			MODE_OFS: rd_byte = {idle_bit_r, on_bit_r, lock_bit_r, 1'b0,
				clk_sel_r, 1'b0};
			CNT_LO_OFS: rd_byte = cnt_r[7:0];
			CNT_HI_OFS: rd_byte = cnt_r[15:8];
			CH5_MODE_OFS: rd_byte = ch5_mode_r;
			WD_OFFSET_OFS: rd_byte = offset_r;
			WD_CMP_OFS: rd_byte = cmp_r;
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read channels: answer one cycle after the address is taken
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			axi_arready_out <= 1'b0;
			axi_rvalid_out <= 1'b0;
			axi_rdata_out <= 32'h00000000;
			axi_rresp_out <= RESP_OKAY;
		end else if (axi_arvalid_in && axi_arready_out) begin
			axi_arready_out <= 1'b0;
			axi_rvalid_out <= 1'b1;
			axi_rdata_out <= {24'h000000, rd_byte};
			axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_rvalid_out) begin
			if (axi_rready_in) begin
				axi_rvalid_out <= 1'b0;
				axi_arready_out <= 1'b1;
			end
		end else begin
			axi_arready_out <= 1'b1;
		end
	end

	// Checks on the watchdog behaviour
	enabled_at_reset_a: assert property (
		@(posedge clk_sys_in) rst_in |=> on_bit_r && wdt_en)
		else $error("watchdog not enabled after reset");
	forced_run_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(wdt_en && sel_tick && !(idle_bit_r && idle_mode_in))
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter did not advance under watchdog");
	counter_frozen_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(wdt_en && !cnt_adv) |=> $stable(cnt_r))
		else $error("counter changed by write under watchdog");
	source_frozen_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		wdt_en |=> $stable(clk_sel_r) && $stable(idle_bit_r))
		else $error("clock select or idle bit changed");
	mode5_locked_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		wdt_en |=> $stable(ch5_mode_r))
		else $error("channel five mode changed under watchdog");
	refresh_load_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(wr_ok && wr_addr == WD_CMP_OFS && wdt_en)
		|=> cmp_r == $past(cnt_r[15:8]) + $past(offset_r))
		else $error("compare byte not reloaded from counter");
	timeout_fire_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(wdt_en && low_ovf && cnt_r[15:8] == cmp_r && !wdt_reset_out)
		|=> wdt_reset_out)
		else $error("missed watchdog timeout reset");
	force_fire_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(force_rst && !wdt_reset_out) |=> wdt_reset_out)
		else $error("forced reset not raised");
	lock_holds_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		lock_bit_r |=> lock_bit_r && wdt_en)
		else $error("locked watchdog was disabled");
	pause_idle_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(idle_bit_r && idle_mode_in) |=> $stable(cnt_r))
		else $error("counter moved while idle suspended");
	reset_pulse_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		wdt_reset_out |=> !wdt_reset_out)
		else $error("reset request longer than one cycle");
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the counter array watchdog
`timescale 1ns/100ps
module tb;
	import wdog_pkg::*;
	// Bench-driven inputs
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic idle_mode_in = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	// Design outputs
	logic awready, wready, bvalid, arready, rvalid, wdt_reset_out;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	// Score and pulse bookkeeping
	int n_errors = 0, n_tests = 0, n_pulse = 0, run_len = 0, max_run = 0;
	int cyc, p0;
	logic [31:0] rd, prev;
	logic [1:0] rsp;

	// 250 MHz clock
	always #2 clk_sys_in = ~clk_sys_in;

	// Spare clock sources idle; write strobe fixed to the used byte
	counter_array_watchdog dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.idle_mode_in(idle_mode_in), .timer_overflow_in(1'b0),
		.ext_clock_pin_in(1'b0), .axi_awvalid_in(awvalid),
		.axi_awready_out(awready), .axi_awaddr_in(awaddr),
		.axi_wvalid_in(wvalid), .axi_wready_out(wready),
		.axi_wdata_in(wdata), .axi_wstrb_in(4'h1),
		.axi_bvalid_out(bvalid), .axi_bready_in(bready),
		.axi_bresp_out(bresp), .axi_arvalid_in(arvalid),
		.axi_arready_out(arready), .axi_araddr_in(araddr),
		.axi_rvalid_out(rvalid), .axi_rready_in(rready),
		.axi_rdata_out(rdata), .axi_rresp_out(rresp),
		.wdt_reset_out(wdt_reset_out));

	// Count reset pulses and their width, sampled mid-cycle
	always @(negedge clk_sys_in) begin
		if (wdt_reset_out === 1'b1) begin
			n_pulse++;
			run_len++;
			if (run_len > max_run)
				max_run = run_len;
		end else
			run_len = 0;
	end

	// Verdict and end of run
	task automatic final_report;
		$display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A wait that ran out ends the run
	task automatic hang;
		n_errors++;
		$display("[ERR] t=%0t wait limit reached", $time);
		final_report();
	endtask

	// Exact value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cycle count within a window
	task automatic chk_in(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// AXI write; ready sampled mid-cycle, released after the taking edge
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		logic ta, tw, tb;
		@(posedge clk_sys_in);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		for (i = 0; i < 100; i++) begin
			@(negedge clk_sys_in);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			tb = bready && bvalid === 1'b1;
			rsp = bresp;
			@(posedge clk_sys_in);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	// AXI read; data and response sampled mid-cycle, before the taking edge
	task automatic axi_rd(input logic [7:0] a);
		int i;
		logic ta, tb;
		@(posedge clk_sys_in);
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= a;
		for (i = 0; i < 100; i++) begin
			@(negedge clk_sys_in);
			ta = arvalid && arready === 1'b1;
			tb = rready && rvalid === 1'b1;
			rd = rdata;
			rsp = rresp;
			@(posedge clk_sys_in);
			if (ta)
				arvalid <= 1'b0;
			if (tb) begin
				rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	// Five-cycle reset, then release
	task automatic do_reset;
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		idle_mode_in <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
	endtask

	// Wait for the next reset pulse, counting cycles
	task automatic wait_pulse(input int lim);
		p0 = n_pulse;
		cyc = 0;
		while (n_pulse == p0) begin
			@(negedge clk_sys_in);
			cyc++;
			if (cyc > lim)
				hang();
		end
	endtask

	// Values after reset, counter forced on
	task automatic t_defaults;
		do_reset();
		axi_rd(MODE_OFS);
		chk(rd, 32'h40);
		axi_rd(WD_OFFSET_OFS);
		chk(rd, 32'h0);
		axi_wr(CTRL_OFS, 8'h00);
		axi_rd(CTRL_OFS);
		chk(rd[CTRL_RUN_BIT], 1'b0);
		axi_rd(CNT_LO_OFS);
		prev = rd;
		repeat (40) @(posedge clk_sys_in);
		axi_rd(CNT_LO_OFS);
		chk(rd !== prev, 1'b1);
		$display("defaults done");
	endtask

	// Protected writes under the enabled watchdog
	task automatic t_locked;
		axi_wr(CNT_HI_OFS, 8'haa);
		axi_rd(CNT_HI_OFS);
		chk(rd, 32'h0);
		axi_wr(CNT_LO_OFS, 8'hf0);
		axi_rd(CNT_LO_OFS);
		chk(rd[7:0] < 8'h40, 1'b1);
		axi_wr(CH5_MODE_OFS, 8'h01);
		axi_wr(MODE_OFS, 8'hc6);
		axi_rd(MODE_OFS);
		chk(rd, 32'h40);
		axi_wr(MODE_OFS, 8'h00);
		axi_rd(MODE_OFS);
		chk(rd, 32'h0);
		axi_rd(CH5_MODE_OFS);
		chk(rd, {24'h0, BYTE_RESET});
		$display("locked writes done");
	endtask

	// Disabled: software control back, then configure and refresh
	task automatic t_refresh;
		axi_wr(CNT_LO_OFS, 8'h12);
		chk(rsp, RESP_OKAY);
		axi_rd(CNT_LO_OFS);
		chk(rd, 32'h12);
		axi_wr(CH5_MODE_OFS, 8'h01);
		axi_rd(CH5_MODE_OFS);
		chk(rd, 32'h01);
		axi_wr(MODE_OFS, 8'h86);
		axi_rd(MODE_OFS);
		chk(rd, 32'h86);
		axi_wr(WD_OFFSET_OFS, 8'h02);
		// Clear flags while stopped, so only a forced match can set one
		axi_wr(CTRL_OFS, 8'h00);
		axi_wr(MODE_OFS, 8'h46);
		axi_wr(WD_CMP_OFS, 8'hff);
		axi_rd(WD_CMP_OFS);
		chk(rd, 32'h02);
		wait_pulse(900);
		chk_in(cyc, 700, 760);
		// Written mode has no match enable; the forced one does
		axi_rd(CTRL_OFS);
		chk(rd[CTRL_CH5_BIT], 1'b1);
		$display("refresh done");
	endtask

	// Default timeout from reset release
	task automatic t_timeout;
		do_reset();
		max_run = 0;
		wait_pulse(4000);
		chk_in(cyc, 3060, 3090);
		repeat (4) @(posedge clk_sys_in);
		chk(max_run, 1);
		$display("timeout done");
	endtask

	// Forced reset by flag write, enabled and disabled
	task automatic t_force;
		do_reset();
		p0 = n_pulse;
		axi_wr(CTRL_OFS, 8'h20);
		repeat (4) @(posedge clk_sys_in);
		chk(n_pulse - p0, 1);
		axi_wr(MODE_OFS, 8'h00);
		p0 = n_pulse;
		axi_wr(CTRL_OFS, 8'h20);
		repeat (4) @(posedge clk_sys_in);
		chk(n_pulse - p0, 0);
		$display("force done");
	endtask

	// Lock bit enables and holds until reset
	task automatic t_lock;
		do_reset();
		axi_wr(MODE_OFS, 8'h20);
		axi_wr(CNT_HI_OFS, 8'h55);
		axi_rd(CNT_HI_OFS);
		chk(rd, 32'h0);
		axi_wr(MODE_OFS, 8'h00);
		axi_wr(CNT_HI_OFS, 8'h55);
		axi_rd(CNT_HI_OFS);
		chk(rd, 32'h0);
		do_reset();
		axi_wr(MODE_OFS, 8'h00);
		axi_wr(CNT_HI_OFS, 8'h55);
		axi_rd(CNT_HI_OFS);
		chk(rd, 32'h55);
		$display("lock done");
	endtask

	// Idle suspend freezes counting
	task automatic t_idle;
		do_reset();
		axi_wr(MODE_OFS, 8'h00);
		axi_wr(MODE_OFS, 8'h86);
		axi_wr(MODE_OFS, 8'hc6);
		idle_mode_in <= 1'b1;
		axi_wr(WD_CMP_OFS, 8'h00);
		axi_rd(CNT_LO_OFS);
		prev = rd;
		repeat (300) @(posedge clk_sys_in);
		axi_rd(CNT_LO_OFS);
		chk(rd, prev);
		chk(n_pulse - p0, 0);
		idle_mode_in <= 1'b0;
		wait_pulse(300);
		chk_in(cyc, 200, 260);
		$display("idle done");
	endtask

	// Unmapped and unaligned addresses
	task automatic t_bus;
		axi_rd(8'h1c);
		chk(rsp, RESP_SLVERR);
		chk(rd, 32'h0);
		axi_rd(8'h02);
		chk(rsp, RESP_SLVERR);
		axi_wr(8'h1c, 8'h5a);
		chk(rsp, RESP_SLVERR);
		$display("bus done");
	endtask

	// Main sequence
	initial begin
		t_defaults();
		t_locked();
		t_refresh();
		t_timeout();
		t_force();
		t_lock();
		p0 = n_pulse;
		t_idle();
		t_bus();
		final_report();
	end
endmodule
